/* src/bsc_special_cells.sv */
// Boundary-scan cells on reset, oscillator, comparator and converter signals.
// Assumes the test port decoder supplies the data-register phase levels and
// the external-test level on the test clock; all of these are sampled here.
//
// Implementation choices: the register addresses and the APB register port.
`default_nettype none
// Functional notes
// - Observe both reset levels with separate cells.
// - Each external oscillator enable gets controllable cell.
// - Oscillator clock outputs are observed, never driven.
// - Timer oscillator scanned like the main clock.
// - Internal RC oscillator output stays out.
// - Unused clock lines read fixed idle values.
// - Oscillator enables are controllable from the chain.
// - Load-capacitor fuses never come from the chain.
// - Comparator signals each get a controllable cell.
// - Converter boundary signals each get a cell.
// - Converter comparator observed, reads zero when idle.
// - Shift registers move least significant bit first.
// - External test applies latches at update.
module bsc_special_cells import bsc_pkg::*; (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              tck,
	input  wire logic              tdi,
	input  wire logic              tap_capture_dr,
	input  wire logic              tap_shift_dr,
	input  wire logic              tap_update_dr,
	input  wire logic              extest_active,
	output logic                   tdo,
	input  wire logic              low_volt_reset_obs,
	input  wire logic              high_volt_reset_obs,
	input  wire logic              ext_clock_line,
	input  wire logic              crystal_osc_clock,
	input  wire logic              ext_rc_clock,
	input  wire logic              low_freq_osc_clock,
	input  wire logic              timer_osc_clock,
	input  wire logic              converter_comp_out,
	input  wire logic [CLK_N-1:0]  clk_option_sel,
	input  wire logic              internal_load_cap_fuse,
	output logic                   osc_load_cap_on,
	input  wire logic              func_ext_clock_in_enable,
	input  wire logic              func_crystal_osc_enable,
	input  wire logic              func_ext_rc_osc_enable,
	input  wire logic              func_low_freq_osc_enable,
	input  wire logic              func_timer_osc_enable,
	input  wire logic              func_comparator_off,
	input  wire logic              func_comparator_result,
	input  wire logic              func_comparator_mux_select,
	input  wire logic              func_comparator_bandgap_enable,
	input  wire logic              func_gain_stage_clock,
	input  wire logic              func_gain_path_enable,
	input  wire logic              func_converter_bandgap_neg_enable,
	input  wire logic              func_converter_power_on,
	output logic                   ext_clock_in_enable,
	output logic                   crystal_osc_enable,
	output logic                   ext_rc_osc_enable,
	output logic                   low_freq_osc_enable,
	output logic                   timer_osc_enable,
	output logic                   comparator_off,
	output logic                   comparator_result,
	output logic                   comparator_mux_select,
	output logic                   comparator_bandgap_enable,
	output logic                   gain_stage_clock,
	output logic                   gain_path_enable,
	output logic                   converter_bandgap_neg_enable,
	output logic                   converter_power_on
);
	// Whole state of the block in one record.
	typedef struct packed {
		logic [SYN_W-1:0] sy1;      // First synchroniser stage.
		logic [SYN_W-1:0] sy2;      // Second stage.
		logic [SYN_W-1:0] sy3;      // Third stage.
		logic [SYN_W-1:0] flt;      // Accepted level once stages agree.
		logic             tck_prev; // Previous accepted test clock.
		logic             tdo;      // Serial output, moves on falling edges.
		logic [CTL_W-1:0] ctl_out;  // Driven controllable signals.
		logic             load_cap; // Fuse copy for the oscillator.
		logic             scan_en;  // Software gate on test clock events.
		bsc_apb_e         apb_st;   // Bus answer state.
		logic             pready;   // Bus answer strobe.
		logic             pslverr;  // Unmapped address answer.
		logic [31:0]      prdata;   // Read data.
	} bsc_state_s;
	bsc_state_s st_reg;
	bsc_state_s st_next;

	// Raw asynchronous inputs gathered for the synchroniser.
	logic [SYN_W-1:0] raw_in;
	// Test clock edges seen on pclk.
	logic             tck_rise;
	logic             tck_fall;
	// Data register phase pulses, one pclk cycle each.
	logic             cap_p;
	logic             shf_p;
	logic             upd_p;
	// Functional values and observed values after idle forcing.
	logic [CTL_W-1:0] func_vec;
	logic [OBS_W-1:0] obs_vec;
	// Chain wiring between the two segments.
	logic             obs_ser;
	logic             ctl_ser;
	logic [OBS_W-1:0] obs_chain;
	logic [CTL_W-1:0] ctl_chain;
	logic [CTL_W-1:0] ctl_latch;
	// Read data chosen by address.
	logic [31:0]      rd_data;
	logic             rd_err;

	// Observed pins; the internal RC oscillator has no pin and no cell.
	assign raw_in = {converter_comp_out, timer_osc_clock, low_freq_osc_clock,
		ext_rc_clock, crystal_osc_clock, ext_clock_line, high_volt_reset_obs,
		low_volt_reset_obs, extest_active, tap_update_dr, tap_shift_dr,
		tap_capture_dr, tdi, tck};

	// Oscillator enables and comparator/converter inputs, low bit first.
	assign func_vec = {func_converter_power_on, func_converter_bandgap_neg_enable,
		func_gain_path_enable, func_gain_stage_clock,
		func_comparator_bandgap_enable, func_comparator_mux_select,
		func_comparator_result, func_comparator_off, func_timer_osc_enable,
		func_low_freq_osc_enable, func_ext_rc_osc_enable,
		func_crystal_osc_enable, func_ext_clock_in_enable};

	// Edges are found on the filtered clock, gated by the software enable.
	assign tck_rise = st_reg.scan_en & st_reg.flt[IX_TCK] & ~st_reg.tck_prev;
	assign tck_fall = st_reg.scan_en & ~st_reg.flt[IX_TCK] & st_reg.tck_prev;
	assign cap_p = tck_rise & st_reg.flt[IX_CAP];
	assign shf_p = tck_rise & st_reg.flt[IX_SHF];
	assign upd_p = tck_fall & st_reg.flt[IX_UPD];

	// Builds the observed word; unused clock options read their idle level.
	always_comb begin
		obs_vec = st_reg.flt[IX_OBS +: OBS_W];
		// Both reset levels stay as sampled, one cell each.
		for (int i = 0; i < CLK_N; i++) begin
			if (!clk_option_sel[i]) begin
				obs_vec[OB_CLK + i] = CLK_IDLE_VAL[i];
			end
		end
		// The converter comparator reads low while the converter is off.
		if (!st_reg.ctl_out[CT_ADC_PWR]) begin
			obs_vec[OB_ADC] = 1'b0;
		end
	end

	// Observe-only segment: reset levels, clock lines, converter comparator.
	bsc_obs_chain #(
		.W(OBS_W)
	) u_obs (
		.pclk    (pclk),
		.presetn (presetn),
		.capture (cap_p),
		.shift   (shf_p),
		.ser_in  (st_reg.flt[IX_TDI]),
		.obs_in  (obs_vec),
		.ser_out (obs_ser),
		.chain   (obs_chain)
	);

	// Controllable segment: oscillator enables, comparator, converter.
	bsc_ctl_chain #(
		.W(CTL_W)
	) u_ctl (
		.pclk    (pclk),
		.presetn (presetn),
		.capture (cap_p),
		.shift   (shf_p),
		.update  (upd_p),
		.ser_in  (obs_ser),
		.cap_in  (st_reg.ctl_out),
		.ser_out (ctl_ser),
		.chain   (ctl_chain),
		.latch   (ctl_latch)
	);

	// Read multiplexer; unmapped addresses answer with an error.
	always_comb begin
		rd_data = '0;
		rd_err  = 1'b0;
		if (paddr == OFF_CTRL) begin
			rd_data[CTRL_SCAN_EN] = st_reg.scan_en;
		end else if (paddr == OFF_STATUS) begin
			rd_data[ST_EXTEST] = st_reg.flt[IX_EXT];
			rd_data[ST_TCK] = st_reg.flt[IX_TCK];
			rd_data[ST_SEL_LSB +: CLK_N] = clk_option_sel;
		end else if (paddr == OFF_CHAIN) begin
			rd_data[OBS_W-1:0] = obs_chain;
			rd_data[OBS_W +: CTL_W] = ctl_chain;
		end else if (paddr == OFF_LATCH) begin
			rd_data[CTL_W-1:0] = ctl_latch;
		end else begin
			rd_err = 1'b1;
		end
	end

	// Next-state logic for synchroniser, link edges, outputs and bus.
	always_comb begin
		st_next = st_reg;
		// Three stages; a level is accepted when stages two and three agree.
		st_next.sy1 = raw_in;
		st_next.sy2 = st_reg.sy1;
		st_next.sy3 = st_reg.sy2;
		st_next.flt = (st_reg.sy2 & st_reg.sy3) |
			(st_reg.flt & (st_reg.sy2 | st_reg.sy3));
		st_next.tck_prev = st_reg.flt[IX_TCK];
		// Serial output changes on the falling test clock edge.
		if (tck_fall) begin
			st_next.tdo = ctl_ser;
		end
		// Latches drive only under external test, else functional logic.
		if (st_reg.flt[IX_EXT]) begin
			st_next.ctl_out = ctl_latch;
		end else begin
			st_next.ctl_out = func_vec;
		end
		// The load capacitor follows its fuse only; the chain cannot touch it.
		st_next.load_cap = internal_load_cap_fuse;
		// Bus answer: one wait cycle, write takes effect as pready is sampled.
		case (st_reg.apb_st)
			BSC_APB_IDLE: begin
				if (psel && penable) begin
					st_next.apb_st  = BSC_APB_RESP;
					st_next.pready  = 1'b1;
					st_next.pslverr = rd_err;
					st_next.prdata  = pwrite ? '0 : rd_data;
				end
			end
			BSC_APB_RESP: begin
				if (pwrite && !st_reg.pslverr && paddr == OFF_CTRL) begin
					st_next.scan_en = pwdata[CTRL_SCAN_EN];
				end
				st_next.apb_st  = BSC_APB_IDLE;
				st_next.pready  = 1'b0;
				st_next.pslverr = 1'b0;
			end
			default: begin
				st_next.apb_st = BSC_APB_IDLE;
				st_next.pready = 1'b0;
			end
		endcase
	end

	// Registers the state copy; every field takes a constant at reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg          <= '0;
			st_reg.scan_en  <= CTRL_SCAN_EN_RST;
			st_reg.apb_st   <= BSC_APB_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs come straight from the state record.
	assign prdata  = st_reg.prdata;
	assign pready  = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign tdo     = st_reg.tdo;
	assign osc_load_cap_on              = st_reg.load_cap;
	assign ext_clock_in_enable          = st_reg.ctl_out[0];
	assign crystal_osc_enable           = st_reg.ctl_out[1];
	assign ext_rc_osc_enable            = st_reg.ctl_out[2];
	assign low_freq_osc_enable          = st_reg.ctl_out[3];
	assign timer_osc_enable             = st_reg.ctl_out[4];
	assign comparator_off               = st_reg.ctl_out[5];
	assign comparator_result            = st_reg.ctl_out[6];
	assign comparator_mux_select        = st_reg.ctl_out[7];
	assign comparator_bandgap_enable    = st_reg.ctl_out[8];
	assign gain_stage_clock             = st_reg.ctl_out[9];
	assign gain_path_enable             = st_reg.ctl_out[10];
	assign converter_bandgap_neg_enable = st_reg.ctl_out[11];
	assign converter_power_on           = st_reg.ctl_out[12];

	// Checks of the cell behaviour, all on pclk.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Serial output only moves one cycle after a falling test clock edge.
	property p_tdo_on_fall;
		$changed(st_reg.tdo) |-> $past(tck_fall);
	endproperty
	a_tdo_on_fall: assert property (p_tdo_on_fall)
		else $error("tdo moved without a falling test clock edge");

	// Shift brings the accepted data input into the top observe cell.
	property p_shift_in;
		(shf_p && !cap_p) |=> obs_chain[OBS_W-1] == $past(st_reg.flt[IX_TDI]);
	endproperty
	a_shift_in: assert property (p_shift_in)
		else $error("shift did not load data input into top cell");

	// Under external test the outputs follow the update latches.
	property p_extest_drive;
		st_reg.flt[IX_EXT] |=> st_reg.ctl_out == $past(ctl_latch);
	endproperty
	a_extest_drive: assert property (p_extest_drive)
		else $error("latch value not applied under external test");

	// Without external test the functional values pass through.
	property p_func_drive;
		!st_reg.flt[IX_EXT] |=> st_reg.ctl_out == $past(func_vec);
	endproperty
	a_func_drive: assert property (p_func_drive)
		else $error("functional value not passed outside external test");

	// The load capacitor copy follows its fuse one cycle later.
	property p_load_cap;
		##1 osc_load_cap_on == $past(internal_load_cap_fuse);
	endproperty
	a_load_cap: assert property (p_load_cap)
		else $error("load capacitor output does not follow its fuse");

	// An unused external RC clock line captures as one.
	property p_rc_idle;
		(cap_p && !clk_option_sel[2]) |=> obs_chain[OB_CLK + 2];
	endproperty
	a_rc_idle: assert property (p_rc_idle)
		else $error("unused external RC clock line did not read one");

	// An unused external clock line captures as zero.
	property p_ext_idle;
		(cap_p && !clk_option_sel[0]) |=> !obs_chain[OB_CLK];
	endproperty
	a_ext_idle: assert property (p_ext_idle)
		else $error("unused external clock line did not read zero");

	// The converter comparator captures zero while the converter is off.
	property p_adc_idle;
		(cap_p && !st_reg.ctl_out[CT_ADC_PWR]) |=> !obs_chain[OB_ADC];
	endproperty
	a_adc_idle: assert property (p_adc_idle)
		else $error("converter comparator not zero while converter off");

	// Both reset levels are captured as sampled.
	property p_reset_obs;
		cap_p |=> obs_chain[OB_HVR:OB_LVR] ==
			$past(st_reg.flt[IX_OBS + OB_HVR:IX_OBS + OB_LVR]);
	endproperty
	a_reset_obs: assert property (p_reset_obs)
		else $error("reset levels not captured");

	// Main scenarios.
	c_capture: cover property (cap_p);
	c_update_extest: cover property (upd_p ##[1:40] st_reg.flt[IX_EXT]);
	c_apb_write: cover property (st_reg.pready && pwrite && paddr == OFF_CTRL);
endmodule
`default_nettype wire

/* src/bsc_pkg.sv */
// Shared constants for the special boundary-scan cells block.
// Assumes a single pclk domain and an APB master with 32-bit data.
`default_nettype none
package bsc_pkg;
	// Chain sizes: observe-only cells and general controllable cells.
	localparam int OBS_W = 8;
	localparam int CTL_W = 13;
	// APB geometry and register byte offsets.
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_CHAIN  = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_LATCH  = 12'h00C;
	// Field positions.
	localparam int CTRL_SCAN_EN = 0;
	localparam int ST_EXTEST    = 0;
	localparam int ST_TCK       = 1;
	localparam int ST_SEL_LSB   = 2;
	localparam logic CTRL_SCAN_EN_RST = 1'b1;
	// Value a scanned clock line reads when its option is unused.
	// Order: external, crystal, external RC, low-frequency, timer.
	localparam int CLK_N = 5;
	localparam logic [CLK_N-1:0] CLK_IDLE_VAL = 5'h04;
	// Synchroniser vector layout: link strobes first, then observed pins.
	localparam int IX_TCK = 0;
	localparam int IX_TDI = 1;
	localparam int IX_CAP = 2;
	localparam int IX_SHF = 3;
	localparam int IX_UPD = 4;
	localparam int IX_EXT = 5;
	localparam int IX_OBS = 6;
	localparam int SYN_W  = IX_OBS + OBS_W;
	// Observe chain positions (bit 0 is nearest the serial output).
	localparam int OB_LVR = 0;
	localparam int OB_HVR = 1;
	localparam int OB_CLK = 2;
	localparam int OB_ADC = 7;
	// Controllable chain positions.
	localparam int CT_ADC_PWR = 12;
	// Bus answer state machine.
	typedef enum logic [1:0] {
		BSC_APB_IDLE = 2'b01,
		BSC_APB_RESP = 2'b10
	} bsc_apb_e;
endpackage
`default_nettype wire

/* src/bsc_obs_chain.sv */
// A row of observe-only scan cells forming one shift segment.
// Assumes capture and shift arrive as one-cycle pulses on pclk.
`default_nettype none
module bsc_obs_chain import bsc_pkg::*; #(
	parameter int W = OBS_W
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         capture,
	input  wire logic         shift,
	input  wire logic         ser_in,
	input  wire logic [W-1:0] obs_in,
	output logic              ser_out,
	output logic [W-1:0]      chain
);
	// The whole state is the shift register; there is no update latch.
	typedef struct packed {
		logic [W-1:0] sr;
	} bsc_obs_s;
	bsc_obs_s st_reg;
	bsc_obs_s st_next;

	// Capture loads the observed signals, shift moves one place toward bit 0.
	always_comb begin
		st_next = st_reg;
		if (capture) begin
			st_next.sr = obs_in;
		end else if (shift) begin
			st_next.sr = {ser_in, st_reg.sr[W-1:1]};
		end
	end

	// Registers the state copy.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// The lowest cell leaves the segment first.
	assign ser_out = st_reg.sr[0];
	assign chain   = st_reg.sr;
endmodule
`default_nettype wire

/* src/bsc_ctl_chain.sv */
// A row of general controllable scan cells: shift stage plus update latch.
// Assumes capture, shift and update arrive as one-cycle pulses on pclk.
`default_nettype none
module bsc_ctl_chain import bsc_pkg::*; #(
	parameter int W = CTL_W
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         capture,
	input  wire logic         shift,
	input  wire logic         update,
	input  wire logic         ser_in,
	input  wire logic [W-1:0] cap_in,
	output logic              ser_out,
	output logic [W-1:0]      chain,
	output logic [W-1:0]      latch
);
	// Shift stage and update latch of every cell.
	typedef struct packed {
		logic [W-1:0] sr;
		logic [W-1:0] lat;
	} bsc_ctl_s;
	bsc_ctl_s st_reg;
	bsc_ctl_s st_next;

	// Capture samples the driven signals; update copies the shift stage.
	always_comb begin
		st_next = st_reg;
		if (capture) begin
			st_next.sr = cap_in;
		end else if (shift) begin
			st_next.sr = {ser_in, st_reg.sr[W-1:1]};
		end
		if (update) begin
			st_next.lat = st_reg.sr;
		end
	end

	// Registers the state copy.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign ser_out = st_reg.sr[0];
	assign chain   = st_reg.sr;
	assign latch   = st_reg.lat;
endmodule
`default_nettype wire

/* verif/bsc_tester.sv */
// Tester model: drives the test clock, test data and data-register phase levels.
// Assumes the bench's pclk paces it; the test clock stands still between frames.
`default_nettype none
module bsc_tester (
	input  wire logic pclk,
	input  wire logic tdo,
	output logic      tck,
	output logic      tdi,
	output logic      cap,
	output logic      shf,
	output logic      upd
);
	timeunit 1ns;
	timeprecision 1ps;
	// No phase active and the clock low until a frame starts.
	initial begin
		{tck, tdi, cap, shf, upd} = 5'h00;
	end
	// Waits a number of pclk edges.
	task automatic ticks(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One 80 ns test clock period; tdo is read late in the high phase, and the
	// next data bit is presented at the fall so it is settled before the rise.
	task automatic pulse(input logic nxt, output logic seen);
		tck <= 1'b1;
		ticks(4);
		seen = tdo;
		tck <= 1'b0;
		tdi <= nxt;
		ticks(4);
	endtask
	// Capture, then shift the whole chain once, least significant bit first.
	task automatic scan(input logic [20:0] din, output logic [20:0] dout);
		logic b;
		cap <= 1'b1;
		ticks(5);
		pulse(din[0], b);
		cap <= 1'b0;
		shf <= 1'b1;
		ticks(5);
		// The last bit is followed by its inverse so a stale level is not mistaken.
		for (int i = 0; i < 21; i++) begin
			pulse((i < 20) ? din[i+1] : ~din[20], dout[i]);
		end
		shf <= 1'b0;
		ticks(5);
	endtask
	// One clock period with the update level held across the falling edge.
	task automatic update();
		logic b;
		upd <= 1'b1;
		ticks(5);
		pulse(~tdi, b);
		ticks(5);
		upd <= 1'b0;
		ticks(5);
	endtask
endmodule
`default_nettype wire

/* verif/test_boundary_scan_special_cells.sv */
// Bench for the special scan cells: APB master, tester model and checks.
// Assumes one APB wait state and a test clock sampled on pclk.
`default_nettype none
module test_boundary_scan_special_cells import bsc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic ext = 1'b0, fuse = 1'b0, er;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, rd;
	logic [12:0] f = '0, lat = '0; // Functional values and the expected latches.
	logic [7:0] o = '0;            // Observed pin levels.
	logic [4:0] sel = '0;          // Clock option fuses.
	logic [20:0] din, dout;
	wire [31:0] prdata;
	wire [12:0] d;
	wire pready, pslverr, tck, tdi, cap, shf, upd, tdo, lcap;
	int mismatches = 0, num_checks = 0, cyc = 0;
	bsc_special_cells dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .tck, .tdi, .tap_capture_dr(cap), .tap_shift_dr(shf),
		.tap_update_dr(upd), .extest_active(ext), .tdo, .low_volt_reset_obs(o[0]),
		.high_volt_reset_obs(o[1]), .ext_clock_line(o[2]), .crystal_osc_clock(o[3]),
		.ext_rc_clock(o[4]), .low_freq_osc_clock(o[5]), .timer_osc_clock(o[6]),
		.converter_comp_out(o[7]), .clk_option_sel(sel), .internal_load_cap_fuse(fuse),
		.osc_load_cap_on(lcap), .func_ext_clock_in_enable(f[0]),
		.func_crystal_osc_enable(f[1]), .func_ext_rc_osc_enable(f[2]),
		.func_low_freq_osc_enable(f[3]), .func_timer_osc_enable(f[4]),
		.func_comparator_off(f[5]), .func_comparator_result(f[6]),
		.func_comparator_mux_select(f[7]), .func_comparator_bandgap_enable(f[8]),
		.func_gain_stage_clock(f[9]), .func_gain_path_enable(f[10]),
		.func_converter_bandgap_neg_enable(f[11]), .func_converter_power_on(f[12]),
		.ext_clock_in_enable(d[0]), .crystal_osc_enable(d[1]), .ext_rc_osc_enable(d[2]),
		.low_freq_osc_enable(d[3]), .timer_osc_enable(d[4]), .comparator_off(d[5]),
		.comparator_result(d[6]), .comparator_mux_select(d[7]),
		.comparator_bandgap_enable(d[8]), .gain_stage_clock(d[9]), .gain_path_enable(d[10]),
		.converter_bandgap_neg_enable(d[11]), .converter_power_on(d[12]));
	bsc_tester tester (.pclk, .tdo, .tck, .tdi, .cap, .shf, .upd);
	// Free-running system clock.
	initial begin
		forever #5 pclk = ~pclk;
	end
	// Cuts a hang short and counts it as a mismatch.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches++;
			give_verdict();
		end
	end
	// Counts a comparison and reports a difference.
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Prints the verdict and ends the run.
	task automatic give_verdict();
		if (mismatches == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Waits a number of pclk edges.
	task automatic ticks(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One APB transfer; the request holds until pready is seen at an edge.
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Image a capture loads: observe cells above the driven values.
	function automatic logic [20:0] exp_cap(input logic [12:0] drv);
		logic [7:0] ob;
		ob[1:0] = o[1:0];
		for (int i = 0; i < 5; i++) ob[2+i] = sel[i] ? o[2+i] : (i == 2);
		ob[7] = o[7] & drv[12];
		return {ob, drv};
	endfunction
	// Main sequence: reset, registers, random scan rounds, scan disabled.
	initial begin
		void'($urandom(32'hEDC2D191));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		ticks(6);
		apb(0, OFF_CTRL, 0, rd, er);
		check("ctrl reset", 32'h1, rd);
		apb(0, 12'h010, 0, rd, er);
		check("unmapped err", 1, er);
		check("unmapped data", 0, rd);
		// A write to a hole must be refused and must leave the control bit alone.
		apb(1, 12'h010, 32'h0, rd, er);
		check("unmapped wr err", 1, er);
		apb(0, OFF_STATUS, 0, rd, er);
		check("status sel", sel, rd[6:2]);
		// First rounds use all options unused and fixed external-test levels, then random.
		for (int i = 0; i < 8; i++) begin
			@(posedge pclk);
			f <= 13'($urandom);
			// Clock lines stand still over a scan, as a supplied clock would.
			o <= 8'($urandom);
			// The option fuses stay fixed for the whole round.
			sel <= (i < 2) ? 5'h00 : 5'($urandom);
			fuse <= 1'($urandom);
			ext <= (i < 2) ? i[0] : 1'($urandom);
			din = (i == 0) ? 21'h000020 : 21'($urandom);
			if (i > 0) din[3:0] = 4'(1 << $urandom_range(4, 0));
			ticks(8);
			// Status shows the filtered test level, an idle test clock and the fuses.
			apb(0, OFF_STATUS, 0, rd, er);
			check("status", (32'(sel) << ST_SEL_LSB) | (32'(ext) << ST_EXTEST), rd);
			check("load cap", fuse, lcap);
			check("drive", ext ? lat : f, d);
			tester.scan(din, dout);
			check("scan out", exp_cap(ext ? lat : f), dout);
			tester.update();
			lat = din[12:0];
			apb(0, OFF_LATCH, 0, rd, er);
			check("latch", lat, rd);
			check("latch err", 0, er);
			apb(0, OFF_CHAIN, 0, rd, er);
			check("chain", {din[12:0], din[20:13]}, rd);
			check("drive upd", ext ? lat : f, d);
		end
		apb(1, OFF_CTRL, 0, rd, er);
		apb(0, OFF_CTRL, 0, rd, er);
		check("ctrl rw", 0, rd);
		tester.scan(~din, dout);
		tester.update();
		apb(0, OFF_LATCH, 0, rd, er);
		check("latch held", lat, rd);
		give_verdict();
	end
endmodule
`default_nettype wire
